// *** src/ppec_pkg.sv ***
package ppec_pkg;

  // port population: two copper ports, numbered from one in the address map
  localparam int unsigned PPEC_NUM_PORTS = 2;
  localparam logic [3:0] PPEC_FIRST_PORT = 4'h1;
  localparam int unsigned PPEC_REG_W = 16;
  localparam int unsigned PPEC_EVT_W = 8;

  // register indices; byte address is four times the index
  localparam int unsigned PPEC_BYTE_SHIFT = 2;
  localparam int unsigned PPEC_IDX_W = 16;
  localparam int unsigned PPEC_PORT_LSB = 12;
  localparam int unsigned PPEC_PORT_NUM_W = 4;
  localparam int unsigned PPEC_OFS_W = 12;
  localparam logic [11:0] PPEC_IDX_EVT = 12'h136;
  localparam logic [11:0] PPEC_IDX_XOVER = 12'h138;
  localparam logic [11:0] PPEC_IDX_SPECIAL = 12'h13C;
  localparam logic [11:0] PPEC_IDX_CTRL = 12'h13E;

  // field positions
  localparam int unsigned PPEC_EN_LSB = 8;
  localparam int unsigned PPEC_FLAG_LSB = 0;
  localparam int unsigned PPEC_XOVER_STRAIGHT_BIT = 7;
  localparam int unsigned PPEC_XOVER_AUTO_OFF_BIT = 6;
  localparam int unsigned PPEC_SPECIAL_SINGLE_IND_BIT = 9;
  localparam int unsigned PPEC_CTRL_JABBER_EN_BIT = 9;
  localparam int unsigned PPEC_CTRL_SPEED100_BIT = 5;
  localparam int unsigned PPEC_CTRL_SPEED10_BIT = 4;
  localparam int unsigned PPEC_CTRL_DUPLEX_BIT = 3;

  // reset values and writable masks
  localparam logic [15:0] PPEC_EVT_EN_RST = 16'h0000;
  localparam logic [15:0] PPEC_EVT_WMASK = 16'hFF00;
  localparam logic [15:0] PPEC_XOVER_RST = 16'h2400;
  localparam logic [15:0] PPEC_XOVER_WMASK = 16'hFFFF;
  localparam logic [15:0] PPEC_SPECIAL_RST = 16'hF800;
  localparam logic [15:0] PPEC_SPECIAL_WMASK = 16'hFFFF;
  localparam logic [15:0] PPEC_CTRL_RST = 16'h0300;
  localparam logic [15:0] PPEC_CTRL_WMASK = 16'hF382;
  localparam logic [15:0] PPEC_CTRL_RC_MASK = 16'h0002;

  // bus encodings
  localparam int unsigned PPEC_HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] PPEC_HSIZE_WORD = 3'h2;
  localparam logic PPEC_HRESP_OKAY = 1'b0;

  // event flag order, msb first so jabber lands on bit 7
  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_received;
    logic parallel_fault;
    logic partner_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } ppec_evt_s;

  // line-side status from one transceiver, asynchronous to the bus clock
  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_received;
    logic parallel_fault;
    logic partner_ack;
    logic remote_fault;
    logic link_status;
    logic speed100;
    logic speed10;
    logic full_duplex;
  } ppec_line_s;

  // controls handed to one transceiver
  typedef struct packed {
    logic straight_sel;
    logic auto_xover_en;
    logic jabber_cnt_en;
    logic single_indicator_mode;
  } ppec_ctrl_s;

  typedef enum logic [2:0] {
    PPEC_SEL_NONE,
    PPEC_SEL_EVT,
    PPEC_SEL_XOVER,
    PPEC_SEL_SPECIAL,
    PPEC_SEL_CTRL
  } ppec_sel_e;

  typedef struct packed {
    logic hit;
    logic [3:0] port;
    ppec_sel_e sel;
  } ppec_dec_s;

endpackage : ppec_pkg

// *** src/ppec_sync.sv ***
// two-stage synchroniser; the first stage feeds only the second
module ppec_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;

  // both stages freeze with the clock enable, as all other state does
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else if (ce_in) begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule : ppec_sync

// *** src/ppec_regs.sv ***
// Operation
// - eight event enables, bits 15..8, reset zero
// - jabber sets bit 7, cleared by read
// - receive error sets bit 6, read clears
// - page received sets bit 5, read clears
// - parallel detect fault sets bit 4
// - partner acknowledge sets bit 3, read clears
// - link down sets bit 2, read clears
// - remote fault sets bit 1, read clears
// - link up sets bit 0, read clears
// - bit 7 forces straight/crossed when auto off
// - bit 6 disables automatic crossover, reset zero
// - control bit 9 enables jabber counter, reset one
// - speed and duplex status bits 5, 4, 3
module ppec_regs
  import ppec_pkg::*;
#(
  parameter int unsigned NUM_PORTS = ppec_pkg::PPEC_NUM_PORTS
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire ppec_pkg::ppec_line_s [NUM_PORTS-1:0] line_in,
  output ppec_pkg::ppec_ctrl_s [NUM_PORTS-1:0] ctrl_out,
  output logic [NUM_PORTS-1:0] irq_out
);

  import ppec_pkg::*;

  localparam int unsigned LINE_W = $bits(ppec_line_s);
  localparam logic [3:0] LAST_PORT = 4'(PPEC_FIRST_PORT + 4'(NUM_PORTS - 1));

  // address decode, shared by the read and the write paths
  function automatic ppec_dec_s ppec_decode(input logic [31:0] addr);
    ppec_dec_s dec;
    logic [15:0] idx;
    logic [3:0] pnum;
    logic [11:0] ofs;
    dec.hit = 1'b0;
    dec.port = '0;
    dec.sel = PPEC_SEL_NONE;
    idx = addr[PPEC_BYTE_SHIFT +: PPEC_IDX_W];
    pnum = idx[PPEC_PORT_LSB +: PPEC_PORT_NUM_W];
    ofs = idx[PPEC_OFS_W-1:0];
    if (addr[31:PPEC_BYTE_SHIFT+PPEC_IDX_W] != '0) begin
      dec.sel = PPEC_SEL_NONE;
    end else if (addr[PPEC_BYTE_SHIFT-1:0] != '0) begin
      dec.sel = PPEC_SEL_NONE;
    end else if (pnum < PPEC_FIRST_PORT || pnum > LAST_PORT) begin
      dec.sel = PPEC_SEL_NONE;
    end else if (ofs == PPEC_IDX_EVT) begin
      dec.sel = PPEC_SEL_EVT;
    end else if (ofs == PPEC_IDX_XOVER) begin
      dec.sel = PPEC_SEL_XOVER;
    end else if (ofs == PPEC_IDX_SPECIAL) begin
      dec.sel = PPEC_SEL_SPECIAL;
    end else if (ofs == PPEC_IDX_CTRL) begin
      dec.sel = PPEC_SEL_CTRL;
    end
    dec.hit = (dec.sel != PPEC_SEL_NONE);
    dec.port = 4'(pnum - PPEC_FIRST_PORT);
    return dec;
  endfunction : ppec_decode

  ppec_dec_s addr_dec;
  ppec_dec_s wr_dec_q;
  logic bus_acc;
  logic rd_take;
  logic wr_take;
  logic wr_pend_q;
  logic stall;
  logic [31:0] hrdata_q;
  logic [15:0] rd_value;
  ppec_line_s [NUM_PORTS-1:0] line_sync;
  ppec_line_s [NUM_PORTS-1:0] line_prev_q;
  logic [PPEC_REG_W-1:0] evt_en_q [NUM_PORTS];
  logic [PPEC_EVT_W-1:0] flag_q [NUM_PORTS];
  logic [PPEC_REG_W-1:0] xover_q [NUM_PORTS];
  logic [PPEC_REG_W-1:0] special_q [NUM_PORTS];
  logic [PPEC_REG_W-1:0] ctrl_q [NUM_PORTS];
  logic [PPEC_REG_W-1:0] ctrl_view [NUM_PORTS];
  ppec_ctrl_s [NUM_PORTS-1:0] ctrl_q_out;
  logic [NUM_PORTS-1:0] irq_q;

  // line status crosses from the transceiver clock before anything looks at it
  ppec_sync #(
    .WIDTH(NUM_PORTS * LINE_W)
  ) u_line_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .d_in(line_in),
    .q_out(line_sync)
  );

  // a read landing on the data phase of a write waits one cycle so it sees the new value
  assign stall = wr_pend_q & hsel_in & htrans_in[PPEC_HTRANS_ACTIVE_BIT] & ~hwrite_in;
  assign hreadyout_out = ce_in & ~stall;
  assign hresp_out = PPEC_HRESP_OKAY;
  assign hrdata_out = hrdata_q;

  // address phase qualification
  assign addr_dec = ppec_decode(haddr_in);
  assign bus_acc = hsel_in & htrans_in[PPEC_HTRANS_ACTIVE_BIT] & hready_in & ce_in;
  assign rd_take = bus_acc & ~hwrite_in;
  assign wr_take = bus_acc & hwrite_in & addr_dec.hit & (hsize_in == PPEC_HSIZE_WORD);

  // write address is held for the data phase; the write commits on the next edge
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_q <= 1'b0;
      wr_dec_q <= '0;
    end else if (ce_in) begin
      wr_pend_q <= wr_take;
      if (wr_take) begin
        wr_dec_q <= addr_dec;
      end
    end
  end

  // read data is captured at the address phase edge, unmapped reads return zero
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_q <= '0;
    end else if (ce_in && rd_take) begin
      hrdata_q <= {16'h0000, rd_value};
    end
  end

  // read mux over all ports
  always_comb begin
    rd_value = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (addr_dec.hit && addr_dec.port == 4'(p)) begin
        if (addr_dec.sel == PPEC_SEL_EVT) begin
          rd_value = (evt_en_q[p] & PPEC_EVT_WMASK) | {8'h00, flag_q[p]};
        end else if (addr_dec.sel == PPEC_SEL_XOVER) begin
          rd_value = xover_q[p];
        end else if (addr_dec.sel == PPEC_SEL_SPECIAL) begin
          rd_value = special_q[p];
        end else if (addr_dec.sel == PPEC_SEL_CTRL) begin
          rd_value = ctrl_view[p];
        end
      end
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      logic wr_here;
      logic rd_here;
      logic rd_evt;
      logic rd_ctrl;
      ppec_evt_s evt_set;
      logic [PPEC_EVT_W-1:0] flag_d;
      logic [PPEC_EVT_W-1:0] en_bits;

      assign wr_here = wr_pend_q & (wr_dec_q.port == 4'(gp));
      assign rd_here = rd_take & addr_dec.hit & (addr_dec.port == 4'(gp));
      assign rd_evt = rd_here & (addr_dec.sel == PPEC_SEL_EVT);
      assign rd_ctrl = rd_here & (addr_dec.sel == PPEC_SEL_CTRL);
      assign en_bits = evt_en_q[gp][PPEC_EN_LSB +: PPEC_EVT_W];

      // previous synchronised line state, for edge detection
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          line_prev_q[gp] <= '0;
        end else if (ce_in) begin
          line_prev_q[gp] <= line_sync[gp];
        end
      end

      // each event is the rising edge of its line condition, jabber only while control bit 9 is set, except link down, which is the falling edge of link status
      always_comb begin
        evt_set.jabber = line_sync[gp].jabber & ~line_prev_q[gp].jabber
                         & ctrl_q[gp][PPEC_CTRL_JABBER_EN_BIT];
        evt_set.rx_error = line_sync[gp].rx_error & ~line_prev_q[gp].rx_error;
        evt_set.page_received = line_sync[gp].page_received & ~line_prev_q[gp].page_received;
        evt_set.parallel_fault = line_sync[gp].parallel_fault & ~line_prev_q[gp].parallel_fault;
        evt_set.partner_ack = line_sync[gp].partner_ack & ~line_prev_q[gp].partner_ack;
        evt_set.link_down = ~line_sync[gp].link_status & line_prev_q[gp].link_status;
        evt_set.remote_fault = line_sync[gp].remote_fault & ~line_prev_q[gp].remote_fault;
        evt_set.link_up = line_sync[gp].link_status & ~line_prev_q[gp].link_status;
      end

      // a new event in the same cycle as the clearing read still sets the flag
      assign flag_d = evt_set | (flag_q[gp] & ~{PPEC_EVT_W{rd_evt}});

      // event flags are set regardless of the enables, which only gate the request
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          flag_q[gp] <= '0;
        end else if (ce_in) begin
          flag_q[gp] <= flag_d;
        end
      end

      // event enables, upper byte only is writable
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          evt_en_q[gp] <= PPEC_EVT_EN_RST;
        end else if (ce_in && wr_here && wr_dec_q.sel == PPEC_SEL_EVT) begin
          evt_en_q[gp] <= hwdata_in[PPEC_REG_W-1:0] & PPEC_EVT_WMASK;
        end
      end

      // crossover register, reserved bits kept as written
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          xover_q[gp] <= PPEC_XOVER_RST;
        end else if (ce_in && wr_here && wr_dec_q.sel == PPEC_SEL_XOVER) begin
          xover_q[gp] <= hwdata_in[PPEC_REG_W-1:0] & PPEC_XOVER_WMASK;
        end
      end

      // special register; the indicator bit is only ever what software puts there
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          special_q[gp] <= PPEC_SPECIAL_RST;
        end else if (ce_in && wr_here && wr_dec_q.sel == PPEC_SEL_SPECIAL) begin
          special_q[gp] <= hwdata_in[PPEC_REG_W-1:0] & PPEC_SPECIAL_WMASK;
        end
      end

      // control register; bit 1 clears when read, and a write never meets a read here
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          ctrl_q[gp] <= PPEC_CTRL_RST;
        end else if (ce_in) begin
          if (wr_here && wr_dec_q.sel == PPEC_SEL_CTRL) begin
            ctrl_q[gp] <= hwdata_in[PPEC_REG_W-1:0] & PPEC_CTRL_WMASK;
          end else if (rd_ctrl) begin
            ctrl_q[gp] <= ctrl_q[gp] & ~PPEC_CTRL_RC_MASK;
          end
        end
      end

      // stored bits merged with the live resolved speed and duplex
      always_comb begin
        ctrl_view[gp] = ctrl_q[gp] & PPEC_CTRL_WMASK;
        ctrl_view[gp][PPEC_CTRL_SPEED100_BIT] = line_sync[gp].speed100;
        ctrl_view[gp][PPEC_CTRL_SPEED10_BIT] = line_sync[gp].speed10;
        ctrl_view[gp][PPEC_CTRL_DUPLEX_BIT] = line_sync[gp].full_duplex;
      end

      // transceiver controls are registered so the outputs never glitch on a write
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          ctrl_q_out[gp] <= '0;
        end else if (ce_in) begin
          ctrl_q_out[gp].auto_xover_en <= ~xover_q[gp][PPEC_XOVER_AUTO_OFF_BIT];
          ctrl_q_out[gp].straight_sel <= xover_q[gp][PPEC_XOVER_AUTO_OFF_BIT]
                                         & xover_q[gp][PPEC_XOVER_STRAIGHT_BIT];
          ctrl_q_out[gp].jabber_cnt_en <= ctrl_q[gp][PPEC_CTRL_JABBER_EN_BIT];
          ctrl_q_out[gp].single_indicator_mode <= special_q[gp][PPEC_SPECIAL_SINGLE_IND_BIT];
        end
      end

      // request follows the flags: it drops the cycle after the clearing read
      always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          irq_q[gp] <= 1'b0;
        end else if (ce_in) begin
          irq_q[gp] <= |(flag_q[gp] & en_bits);
        end
      end
    end
  endgenerate

  assign ctrl_out = ctrl_q_out;
  assign irq_out = irq_q;

endmodule : ppec_regs

// *** verification/ppec_checker.sv ***
module ppec_checker #(
  parameter int unsigned NUM_PORTS = ppec_pkg::PPEC_NUM_PORTS
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire ppec_pkg::ppec_line_s [NUM_PORTS-1:0] line_in,
  input wire ppec_pkg::ppec_ctrl_s [NUM_PORTS-1:0] ctrl_out,
  input wire logic [NUM_PORTS-1:0] irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ppec_pkg::*;
  logic acc;
  logic wr_ok;
  logic rd_e;
  logic rd_c;
  logic wr_e;
  logic wr_x;
  logic wr_c;
  ppec_line_s last_q;
  logic [2:0] stab_q;
  logic [2:0] stab_d;

  // accepted address phases aimed at port 1's registers
  assign acc = hsel_in & htrans_in[1] & hready_in & ce_in;
  assign wr_ok = acc & hwrite_in & (hsize_in == PPEC_HSIZE_WORD);
  assign rd_e = acc & ~hwrite_in & (haddr_in == 32'h000044D8);
  assign rd_c = acc & ~hwrite_in & (haddr_in == 32'h000044F8);
  assign wr_e = wr_ok & (haddr_in == 32'h000044D8);
  assign wr_x = wr_ok & (haddr_in == 32'h000044E0);
  assign wr_c = wr_ok & (haddr_in == 32'h000044F8);
  // how long port 1's line has held still; once high, no event is still in the synchroniser
  assign stab_d = (line_in[0] != last_q) ? 3'h0 : (stab_q == 3'h7) ? stab_q : stab_q + 3'h1;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_q <= '0;
      stab_q <= 3'h0;
    end else begin
      last_q <= line_in[0];
      stab_q <= stab_d;
    end
  end

  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_reset_ctrl: assert property ($rose(rst_n_in) |=> ctrl_out[0] == 4'h6)
    else $error("controls wrong after reset");
  chk_xover_auto: assert property (wr_x ##1 hready_in |-> ##2
    ctrl_out[0].auto_xover_en == !$past(hwdata_in[6], 2))
    else $error("auto crossover not following write");
  chk_xover_straight: assert property (wr_x ##1 hready_in |-> ##2
    ctrl_out[0].straight_sel == ($past(hwdata_in[7], 2) & $past(hwdata_in[6], 2)))
    else $error("straight select not following write");
  chk_jabber_enable: assert property (wr_c ##1 hready_in |-> ##2
    ctrl_out[0].jabber_cnt_en == $past(hwdata_in[9], 2))
    else $error("jabber counter enable not following write");
  chk_speed_bits: assert property (rd_c && stab_q >= 3'h4 |=> hrdata_out[5:3] == $past(line_in[0][2:0], 2))
    else $error("speed or duplex status wrong");
  chk_flag_clear: assert property ((rd_e && stab_q >= 3'h5) ##[1:4] (rd_e && stab_q >= 3'h6)
    |=> hrdata_out[7:0] == 8'h00)
    else $error("event flags survived a read");
  chk_irq_drop: assert property (rd_e && stab_q >= 3'h5 |-> ##2 !irq_out[0])
    else $error("request stayed up after flags cleared");
  chk_irq_cause: assert property ($rose(irq_out[0]) |-> stab_q != 3'h7 || $past(wr_e, 2) || $past(wr_e, 3))
    else $error("request rose with no event and no enable write");

  cov_irq: cover property ($rose(irq_out[0]));
  cov_reread: cover property (rd_e ##[1:4] rd_e);
  cov_xover: cover property (wr_x ##1 hready_in);
  cov_stall: cover property (hsel_in && htrans_in[1] && !hreadyout_out);
endmodule : ppec_checker

bind ppec_regs ppec_checker #(.NUM_PORTS(NUM_PORTS)) u_ppec_checker (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .line_in(line_in), .ctrl_out(ctrl_out), .irq_out(irq_out));

// *** verification/ppec_link_partner.sv ***
module ppec_link_partner (
  input wire logic clock_in,
  output ppec_pkg::ppec_line_s [1:0] line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ppec_pkg::*;

  // both copper ports start quiet, link down
  initial line_out = '0;

  // a condition held four cycles; only its rising edge is an event
  task automatic pulse(input int p, input int b);
    @(posedge clock_in);
    line_out[p][b] <= 1'b1;
    repeat (4) @(posedge clock_in);
    line_out[p][b] <= 1'b0;
  endtask : pulse

  // link, speed and duplex are levels the partner settles on
  task automatic level(input int p, input int b, input logic v);
    @(posedge clock_in);
    line_out[p][b] <= v;
  endtask : level
endmodule : ppec_link_partner

// *** verification/ppec_regs_test.sv ***
module ppec_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ppec_pkg::*;
  localparam logic [31:0] A_EVT = 32'h000044D8;
  localparam logic [31:0] A_XOVER = 32'h000044E0;
  localparam logic [31:0] A_SPEC = 32'h000044F0;
  localparam logic [31:0] A_CTRL = 32'h000044F8;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic [31:0] hrdata_out;
  logic hreadyout_out;
  logic hresp_out;
  ppec_line_s [1:0] line;
  ppec_ctrl_s [1:0] ctrl_out;
  logic [1:0] irq_out;
  int err_count = 0;
  int n_compared = 0;

  always #5 clock_in = ~clock_in;

  ppec_regs #(.NUM_PORTS(2)) u_ppec_regs (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .hsel_in(1'b1), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(PPEC_HSIZE_WORD), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .line_in(line), .ctrl_out(ctrl_out), .irq_out(irq_out));
  ppec_link_partner u_ppec_link_partner (.clock_in(clock_in), .line_out(line));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one word transfer; each phase stands until ready is seen high at a rising edge
  task automatic xfer(input logic [31:0] a, input logic w, input logic [15:0] d, output logic [15:0] q);
    @(posedge clock_in);
    haddr_in <= a;
    hwrite_in <= w;
    htrans_in <= 2'h2;
    do @(posedge clock_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= {16'h0000, d};
    do @(posedge clock_in); while (hreadyout_out !== 1'b1);
    q = hrdata_out[15:0];
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(a, 1'b1, d, q);
    repeat (2) @(negedge clock_in);
  endtask : wr

  task automatic rd_chk(input string n, input logic [31:0] a, input logic [15:0] e);
    logic [15:0] q;
    xfer(a, 1'b0, 16'h0000, q);
    chk(n, e, q);
  endtask : rd_chk

  task automatic t_reset;
    rd_chk("evt_rst", A_EVT, 16'h0000);
    rd_chk("xover_rst", A_XOVER, 16'h2400);
    rd_chk("ctrl_rst", A_CTRL, 16'h0300);
    chk("ctrl_out_rst", 16'h0006, {12'h000, ctrl_out[0]});
    wr(A_EVT, 16'hFFFF);
    rd_chk("evt_en_rw", A_EVT, 16'hFF00);
  endtask : t_reset

  // every event in turn, enabled: request up, flag read once, then gone
  task automatic t_events;
    u_ppec_link_partner.level(0, 3, 1'b1);
    repeat (6) @(negedge clock_in);
    rd_chk("first_up", A_EVT, 16'hFF01);
    for (int i = 7; i >= 0; i--) begin
      if (i == 2 || i == 0) u_ppec_link_partner.level(0, 3, i == 0);
      else u_ppec_link_partner.pulse(0, (i == 1) ? 4 : i + 2);
      repeat (6) @(negedge clock_in);
      chk("irq_set", 16'h0001, {15'h0, irq_out[0]});
      rd_chk("flag_set", A_EVT, 16'hFF00 | (16'h0001 << i));
      rd_chk("flag_clr", A_EVT, 16'hFF00);
      chk("irq_clr", 16'h0000, {15'h0, irq_out[0]});
    end
  endtask : t_events

  // a masked event still flags but raises no request; jabber off stops the flag
  task automatic t_mask;
    wr(A_EVT, 16'h7F00);
    u_ppec_link_partner.pulse(0, 9);
    repeat (6) @(negedge clock_in);
    chk("irq_masked", 16'h0000, {15'h0, irq_out[0]});
    rd_chk("evt_masked", A_EVT, 16'h7F80);
    wr(A_CTRL, 16'h0100);
    chk("jab_off", 16'h0000, {15'h0, ctrl_out[0].jabber_cnt_en});
    u_ppec_link_partner.pulse(0, 9);
    repeat (6) @(negedge clock_in);
    rd_chk("jab_gated", A_EVT, 16'h7F00);
    rd_chk("ctrl_rb", A_CTRL, 16'h0100);
    wr(A_CTRL, 16'h0300);
  endtask : t_mask

  task automatic t_speed;
    u_ppec_link_partner.level(0, 2, 1'b1);
    u_ppec_link_partner.level(0, 0, 1'b1);
    repeat (4) @(negedge clock_in);
    rd_chk("spd100_full", A_CTRL, 16'h0328);
    u_ppec_link_partner.level(0, 2, 1'b0);
    u_ppec_link_partner.level(0, 1, 1'b1);
    u_ppec_link_partner.level(0, 0, 1'b0);
    repeat (4) @(negedge clock_in);
    rd_chk("spd10_half", A_CTRL, 16'h0310);
  endtask : t_speed

  // all four crossover settings, then the indicator bit and the second port
  task automatic t_xover;
    logic [15:0] xd [4] = '{16'h2400, 16'h2440, 16'h24C0, 16'h2480};
    foreach (xd[i]) begin
      wr(A_XOVER, xd[i]);
      chk("auto_x", {15'h0, ~xd[i][6]}, {15'h0, ctrl_out[0].auto_xover_en});
      chk("straight", {15'h0, xd[i][7] & xd[i][6]}, {15'h0, ctrl_out[0].straight_sel});
      rd_chk("xover_rb", A_XOVER, xd[i]);
    end
    wr(A_SPEC, 16'hFA00);
    chk("single_ind", 16'h0001, {15'h0, ctrl_out[0].single_indicator_mode});
    rd_chk("spec_rb", A_SPEC, 16'hFA00);
    wr(32'h000084E0, 16'h2440);
    chk("p2_auto_x", 16'h0000, {15'h0, ctrl_out[1].auto_xover_en});
    rd_chk("p2_evt", 32'h000084D8, 16'h0000);
    rd_chk("unmapped", 32'h00000010, 16'h0000);
  endtask : t_xover

  // read issued in a write's data phase: one wait cycle, then the new value
  task automatic t_b2b;
    int w;
    logic [15:0] q;
    w = 0;
    @(posedge clock_in);
    haddr_in <= A_SPEC;
    hwrite_in <= 1'b1;
    htrans_in <= 2'h2;
    do @(posedge clock_in); while (hreadyout_out !== 1'b1);
    hwdata_in <= 32'h0000F800;
    hwrite_in <= 1'b0;
    @(posedge clock_in);
    while (hreadyout_out !== 1'b1) begin
      w++;
      @(posedge clock_in);
    end
    htrans_in <= 2'h0;
    do @(posedge clock_in); while (hreadyout_out !== 1'b1);
    q = hrdata_out[15:0];
    chk("b2b_wait", 16'h0001, 16'(w));
    chk("b2b_data", 16'hF800, q);
    chk("single_ind_off", 16'h0000, {15'h0, ctrl_out[0].single_indicator_mode});
    chk("hresp", 16'h0000, {15'h0, hresp_out});
  endtask : t_b2b

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_events();
    t_mask();
    t_speed();
    t_xover();
    t_b2b();
    test_done();
  end

  // the run needs about three hundred cycles
  initial begin
    repeat (20000) @(posedge clock_in);
    err_count++;
    test_done();
  end
endmodule : ppec_regs_test
